// [rtl/strap_pkg.sv]
/*
 Package for the boot strap latch and decoder: register map, field positions,
 fuse encodings and reset values.
 Assumes a 32-bit Avalon-MM register bus.
*/
package strap_pkg;
   localparam int STRAP_COUNT = 3;
   localparam logic [3:0] ADDR_STRAP_VALUE = 4'h0;
   localparam logic [3:0] ADDR_BOOT_STATUS = 4'h4;
   localparam logic [3:0] ADDR_FUSE_VIEW = 4'h8;
   localparam int BIT_PRINT_BOOT = 0;
   localparam int BIT_BOOT_SELECT = 1;
   localparam int BIT_DEBUG_SELECT = 2;
   localparam int BIT_STAT_DOWNLOAD = 0;
   localparam int BIT_STAT_PRINT = 1;
   localparam int BIT_STAT_DEBUG_PINS = 2;
   localparam int BIT_STAT_INVALID = 3;
   localparam int BIT_STAT_VALID = 4;
   localparam logic [2:0] STRAP_RESET = 3'h2;
   localparam logic [1:0] PRINT_ALWAYS_ON = 2'h0;
   localparam logic [1:0] PRINT_WHEN_LOW = 2'h1;
   localparam logic [1:0] PRINT_WHEN_HIGH = 2'h2;
   localparam logic [1:0] PRINT_ALWAYS_OFF = 2'h3;
   localparam logic [31:0] UNMAPPED_READ = 32'h0;

   typedef enum logic [0:0] {
      BOOT_FLASH = 1'b0,
      BOOT_DOWNLOAD = 1'b1
   } boot_mode_t;

   typedef struct packed {
      boot_mode_t bootMode;
      logic printEnable;
      logic debugFromPins;
      logic invalidCombo;
   } boot_cfg_t;

   typedef struct packed {
      logic [3:0] address;
      logic read;
      logic write;
      logic [31:0] writedata;
   } avl_req_t;
endpackage

// [rtl/strap_sync.sv]
/*
 Two-flop synchroniser for the strap pin inputs.
 Assumes pins are asynchronous to clk.
*/
`timescale 1ns/10ps
`default_nettype none
module strap_sync #(
   parameter int WIDTH = 3
) (
   // Clocking.
   input wire logic clk,
   input wire logic clkEn,
   // Data.
   input wire logic [WIDTH-1:0] asyncIn,
   output logic [WIDTH-1:0] syncOut
);
   logic [WIDTH-1:0] stage1_r;

   always_ff @(posedge clk) begin
      if (clkEn) begin
         stage1_r <= asyncIn;
         syncOut <= stage1_r;
      end
   end
endmodule
`default_nettype wire

// [rtl/boot_decode.sv]
/*
 Combinational boot decoder from strap bits and fuse fields.
 Assumes strap bits are stable latched values.
*/
`timescale 1ns/10ps
`default_nettype none
module boot_decode (
   // Inputs.
   input wire logic [2:0] strapBits,
   input wire logic [1:0] printPolicyFuse,
   input wire logic debugSourceSelectFuse,
   // Result.
   output strap_pkg::boot_cfg_t cfg
);
   import strap_pkg::*;

   logic printBoot;
   logic bootSel;
   logic debugSel;

   always_comb begin
      printBoot = strapBits[BIT_PRINT_BOOT];
      bootSel = strapBits[BIT_BOOT_SELECT];
      debugSel = strapBits[BIT_DEBUG_SELECT];
      // Boot select high wins; low means download.
      cfg.bootMode = bootSel ? BOOT_FLASH : BOOT_DOWNLOAD;
      cfg.invalidCombo = !bootSel && !printBoot;
      case (printPolicyFuse)
         PRINT_ALWAYS_ON: cfg.printEnable = 1'b1;
         PRINT_WHEN_LOW: cfg.printEnable = !printBoot;
         PRINT_WHEN_HIGH: cfg.printEnable = printBoot;
         PRINT_ALWAYS_OFF: cfg.printEnable = 1'b0;
         default: cfg.printEnable = 1'b0;
      endcase
      // Debug pins used only when fuse allows and strap is low.
      cfg.debugFromPins = debugSourceSelectFuse && !debugSel;
   end
endmodule
`default_nettype wire

// [rtl/boot_strap_latch_decode.sv]
/*
 Boot strap latch and decoder with an Avalon-MM register slave.
 Assumes system reset sources are synchronous to clk and the pins have been
 pulled or driven by the board while reset is asserted.
*/
// Implementation choices: the Avalon-MM register port and the address map.
// Functional notes
// - While any system reset is active the three strap pin levels are captured as bits.
// - Captured bits are frozen after reset release until the next system reset.
// - Power-on, slow watchdog, brownout, supervisory watchdog and glitch resets all sample.
// - Software reads the latched bits in the strap value register, one bit per pin.
// - After reset release the pins are handed back to their normal functions.
// - The boot select pin has an internal pull-up on by default.
// - Boot select high means flash boot, low with print/boot high means download boot.
// - Print fuse 0 forces printing on and 3 forces it off, ignoring the strap.
// - Print fuse 1 prints on strap low and 2 prints on strap high.
// - Debug source fuse 0 leaves the debug port unusable.
// - With the fuse at 1 a debug strap of 0 routes debug from pins, 1 disables it.
`timescale 1ns/10ps
`default_nettype none
module boot_strap_latch_decode (
   // Clock and reset.
   input wire logic clk,
   input wire logic clkEn,
   input wire logic rst,
   // System reset sources, active high; chip_power_up_in holds reset while low.
   input wire logic powerOnRst,
   input wire logic slowWatchdogRst,
   input wire logic brownoutRst,
   input wire logic supervisorWatchdogRst,
   input wire logic glitchRst,
   input wire logic chip_power_up_in,
   // Strap pins.
   input wire logic print_boot_strap,
   input wire logic boot_select_strap,
   input wire logic debug_select_strap,
   output logic strapModeActive,
   output logic bootSelectPullUpEn,
   // Fuses.
   input wire logic [1:0] printPolicyFuse,
   input wire logic debug_source_select_fuse,
   // Decoded outputs.
   output strap_pkg::boot_mode_t bootMode,
   output logic printEnable,
   output logic debugFromPins,
   output logic strapInvalid,
   // Avalon-MM slave.
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest
);
   import strap_pkg::*;

   logic [2:0] pinSync;
   logic [2:0] strap_r;
   logic strapValid_r;
   logic sysReset;
   logic sysReset_r;
   logic powerSync1_r;
   logic powerUp_r;
   logic readAck_r;
   boot_cfg_t cfgNow;
   avl_req_t req;

   assign req = '{address: avs_address, read: avs_read, write: avs_write,
                  writedata: avs_writedata};

   strap_sync #(
      .WIDTH(STRAP_COUNT)
   ) pinSyncInst (
      .clk(clk),
      .clkEn(clkEn),
      .asyncIn({debug_select_strap, boot_select_strap, print_boot_strap}),
      .syncOut(pinSync)
   );

   // Chip power-up pin passes two flops.
   always_ff @(posedge clk) begin
      if (rst) begin
         powerSync1_r <= 1'b0;
         powerUp_r <= 1'b0;
      end else if (clkEn) begin
         powerSync1_r <= chip_power_up_in;
         powerUp_r <= powerSync1_r;
      end
   end

   // Any reset source, or chip held off, counts as system reset.
   assign sysReset = powerOnRst || slowWatchdogRst || brownoutRst
                     || supervisorWatchdogRst || glitchRst || !powerUp_r;

   always_ff @(posedge clk) begin
      if (rst) begin
         sysReset_r <= 1'b1;
      end else if (clkEn) begin
         sysReset_r <= sysReset;
      end
   end

   // Strap latch follows pins only during system reset, then holds.
   always_ff @(posedge clk) begin
      if (rst) begin
         strap_r <= STRAP_RESET;
         strapValid_r <= 1'b0;
      end else if (clkEn) begin
         if (sysReset) begin
            strap_r <= pinSync;
            strapValid_r <= 1'b1;
         end
      end
   end

   // Pins act as straps only while reset holds; the boot select pull-up is always on.
   assign strapModeActive = sysReset_r;
   assign bootSelectPullUpEn = 1'b1;

   boot_decode decodeInst (
      .strapBits(strap_r),
      .printPolicyFuse(printPolicyFuse),
      .debugSourceSelectFuse(debug_source_select_fuse),
      .cfg(cfgNow)
   );

   // Decoded results registered for output.
   always_ff @(posedge clk) begin
      if (rst) begin
         bootMode <= BOOT_FLASH;
         printEnable <= 1'b0;
         debugFromPins <= 1'b0;
         strapInvalid <= 1'b0;
      end else if (clkEn) begin
         bootMode <= cfgNow.bootMode;
         printEnable <= cfgNow.printEnable;
         debugFromPins <= cfgNow.debugFromPins;
         strapInvalid <= cfgNow.invalidCombo;
      end
   end

   // Reads answer one cycle after the request; writes complete at once.
   assign avs_waitrequest = req.read && !readAck_r;

   always_ff @(posedge clk) begin
      if (rst) begin
         readAck_r <= 1'b0;
         avs_readdata <= UNMAPPED_READ;
      end else if (clkEn) begin
         readAck_r <= req.read && !readAck_r;
         if (req.read && !readAck_r) begin
            case (req.address)
               ADDR_STRAP_VALUE: avs_readdata <= {29'h0, strap_r};
               ADDR_BOOT_STATUS: avs_readdata <= {27'h0, strapValid_r, strapInvalid,
                                                 debugFromPins, printEnable,
                                                 bootMode == BOOT_DOWNLOAD};
               ADDR_FUSE_VIEW: avs_readdata <= {29'h0, debug_source_select_fuse,
                                               printPolicyFuse};
               default: avs_readdata <= UNMAPPED_READ;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// [verification/strap_properties.sv]
/*
 Checker for the strap latch and decoder ports.
 Assumes one clock domain, reset rst, and is bound to the top module.
*/
`timescale 1ns/10ps
`default_nettype none
module strap_properties (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   input wire logic clkEn,
   // Reset sources.
   input wire logic powerOnRst,
   input wire logic slowWatchdogRst,
   input wire logic brownoutRst,
   input wire logic supervisorWatchdogRst,
   input wire logic glitchRst,
   input wire logic chip_power_up_in,
   // Strap side.
   input wire logic strapModeActive,
   input wire logic bootSelectPullUpEn,
   input wire logic [1:0] printPolicyFuse,
   input wire logic debug_source_select_fuse,
   input wire strap_pkg::boot_mode_t bootMode,
   input wire logic printEnable,
   input wire logic debugFromPins,
   input wire logic strapInvalid,
   // Bus.
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest
);
   import strap_pkg::*;
   wire srcAny = powerOnRst | slowWatchdogRst | brownoutRst | supervisorWatchdogRst | glitchRst;
   default clocking @(posedge clk); endclocking
   default disable iff (rst || !clkEn);
   a_pullup_on: assert property (bootSelectPullUpEn) else $error("pull-up off");
   a_write_nowait: assert property (avs_write |-> !avs_waitrequest) else $error("write stalled");
   a_read_wait: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest) else $error("read timing");
   a_read_upper: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:5] == 27'h0) else $error("upper bits set");
   a_strap_active: assert property (srcAny |-> ##[1:3] strapModeActive) else $error("strap mode missed");
   a_pins_freed: assert property ((!srcAny && chip_power_up_in)[*5] |-> !strapModeActive) else $error("pins held");
   a_mode_frozen: assert property ((!strapModeActive)[*4] |-> $stable(bootMode)) else $error("mode moved");
   a_print_on: assert property ((printPolicyFuse == PRINT_ALWAYS_ON)[*3] |-> printEnable) else $error("print off");
   a_print_off: assert property ((printPolicyFuse == PRINT_ALWAYS_OFF)[*3] |-> !printEnable) else $error("print on");
   a_debug_off: assert property ((!debug_source_select_fuse)[*3] |-> !debugFromPins) else $error("debug on");
   a_mode_valid: assert property (bootMode == BOOT_DOWNLOAD |-> !strapInvalid) else $error("bad combo");
endmodule
bind boot_strap_latch_decode strap_properties strap_properties_i (.clk, .rst, .clkEn,
   .powerOnRst,
   .slowWatchdogRst, .brownoutRst, .supervisorWatchdogRst, .glitchRst, .chip_power_up_in,
   .strapModeActive, .bootSelectPullUpEn, .printPolicyFuse, .debug_source_select_fuse, .bootMode,
   .printEnable, .debugFromPins, .strapInvalid, .avs_read, .avs_write, .avs_readdata,
   .avs_waitrequest);
`default_nettype wire

// [verification/strap_board.sv]
/*
 Board model for the strap pins: resistors or host outputs.
 Assumes the device pull-up acts only on the boot select pin.
*/
`timescale 1ns/10ps
`default_nettype none
module strap_board (
   // Control.
   input wire logic clk,
   input wire logic drive,
   input wire logic pullEn,
   input wire logic [2:0] level,
   // Pins.
   output logic [2:0] pins
);
   logic [2:0] lastV;
   // Released pins drift to the inverse of their last driven level unless pulled up.
   always_ff @(posedge clk) begin
      if (drive) begin
         lastV <= level;
      end
   end
   assign pins = drive ? level : {~lastV[2], pullEn | ~lastV[1], ~lastV[0]};
endmodule
`default_nettype wire

// [verification/tb.sv]
/*
 Self-checking bench for the strap latch and decoder.
 Assumes the board model on the pins and the Avalon-MM timing of the design.
*/
`timescale 1ns/10ps
`default_nettype none
module tb;
   import strap_pkg::*;
   logic clk = 1'h0, rst = 1'h1, drive = 1'h1, pwrUp = 1'h1, dbgFuse = 1'h0, rd = 1'h0, wr = 1'h0;
   logic en = 1'h1;
   logic pullEn, modeAct, prt, dbg, inval, wait_;
   logic [4:0] srcs = 5'h0;
   logic [2:0] level = 3'h3, pins;
   logic [1:0] prtFuse = 2'h0;
   logic [3:0] addr = 4'h0;
   logic [31:0] rdata, rdv;
   logic [2:0] combos [6] = '{3'h3, 3'h1, 3'h6, 3'h7, 3'h2, 3'h5};
   boot_mode_t mode;
   int error_cnt = 0, tests_run = 0;
   strap_board strap_board_i (.clk(clk), .drive(drive), .pullEn(pullEn), .level(level), .pins(pins));
   boot_strap_latch_decode boot_strap_latch_decode_i (.clk(clk), .clkEn(en), .rst(rst),
      .powerOnRst(srcs[0]), .slowWatchdogRst(srcs[1]), .brownoutRst(srcs[2]),
      .supervisorWatchdogRst(srcs[3]), .glitchRst(srcs[4]), .chip_power_up_in(pwrUp),
      .print_boot_strap(pins[0]), .boot_select_strap(pins[1]), .debug_select_strap(pins[2]),
      .strapModeActive(modeAct), .bootSelectPullUpEn(pullEn), .printPolicyFuse(prtFuse),
      .debug_source_select_fuse(dbgFuse), .bootMode(mode), .printEnable(prt),
      .debugFromPins(dbg), .strapInvalid(inval), .avs_address(addr), .avs_read(rd),
      .avs_write(wr), .avs_writedata(32'h7), .avs_readdata(rdata), .avs_waitrequest(wait_));
   initial begin
      forever #2.5 clk = ~clk;
   end
   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic report_and_stop;
      $display("errors %0d checks %0d", error_cnt, tests_run);
      if (error_cnt == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic bus(logic isWr, logic [3:0] a);
      int n;
      @(posedge clk);
      addr <= a;
      rd <= !isWr;
      wr <= isWr;
      for (n = 0; n < 20; n++) begin
         @(posedge clk);
         if (wait_ === 1'b0) break;
      end
      rdv = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
      if (n == 20) begin
         error_cnt++;
         report_and_stop();
      end
   endtask
   task automatic sys_reset(logic [5:0] act);
      srcs <= act[4:0];
      pwrUp <= !act[5];
      repeat (4) @(posedge clk);
      srcs <= 5'h0;
      pwrUp <= 1'b1;
      repeat (3) @(posedge clk);
   endtask
   task automatic boot(logic [2:0] lv, int src);
      level <= lv;
      repeat (3) @(posedge clk);
      sys_reset(6'h1 << src);
      level <= ~lv;
      repeat (3) @(posedge clk);
      check("mode active", modeAct, 0);
      bus(0, ADDR_STRAP_VALUE);
      check("strap", rdv, {29'h0, lv});
      check("boot", mode, lv[1] ? BOOT_FLASH : BOOT_DOWNLOAD);
      check("invalid", inval, 0);
      for (int f = 0; f < 4; f++) begin
         prtFuse <= f[1:0];
         dbgFuse <= f[0];
         repeat (3) @(posedge clk);
         check("print", prt, f == 0 || (f == 1 && !lv[0]) || (f == 2 && lv[0]));
         check("debug", dbg, f[0] && !lv[2]);
      end
   endtask
   task automatic ro_test(logic [2:0] lv);
      bus(1, ADDR_STRAP_VALUE);
      bus(0, ADDR_STRAP_VALUE);
      check("read only", rdv, {29'h0, lv});
      bus(0, 4'hc);
      check("unmapped", rdv, UNMAPPED_READ);
      bus(0, ADDR_BOOT_STATUS);
      check("status", rdv, (32'h1 << BIT_STAT_VALID) | (32'h1 << BIT_STAT_DOWNLOAD));
      bus(0, ADDR_FUSE_VIEW);
      check("fuse view", rdv, {29'h0, 1'b1, PRINT_ALWAYS_OFF});
   endtask
   task automatic freeze_test;
      en <= 1'b0;
      level <= 3'h3;
      sys_reset(6'h2);
      check("frozen mode", modeAct, 0);
      en <= 1'b1;
      bus(0, ADDR_STRAP_VALUE);
      check("frozen strap", rdv, 32'h5);
   endtask
   task automatic float_test;
      drive <= 1'b0;
      sys_reset(6'h4);
      bus(0, ADDR_STRAP_VALUE);
      check("pull-up", rdv[BIT_BOOT_SELECT], 1);
   endtask
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 6; i++) boot(combos[i], i);
      ro_test(3'h5);
      freeze_test();
      float_test();
      report_and_stop();
   end
   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      report_and_stop();
   end
endmodule
`default_nettype wire
